// File: hw/odec_pkg.sv
// Package for the opcode decode slice: opcode patterns, fields, cycle counts and the decode result struct.
// Assumes a 16-bit instruction word and a fetch path that presents one word at a time.
package odec_pkg;

    // ************************************************************
    // Opcode patterns and field positions
    // ************************************************************
    localparam logic [7:0]  OP_BRANCH_HI   = 8'he3;   // Conditional branch, condition group.
    localparam logic [7:0]  OP_BR_NZ_LO    = 8'h08;   // Branch if accumulator nonzero.
    localparam logic [7:0]  OP_BR_OV_LO    = 8'h22;   // Branch on overflow.
    localparam logic [7:0]  OP_BR_EQ_LO    = 8'h88;   // Branch if accumulator zero.
    localparam logic [3:0]  OP_PROBE_NIB   = 4'h4;    // Bit probe, position in bits 11:8.
    localparam logic [7:0]  OP_PROBE_MULTIPLIER_OPERAND_REG  = 8'h6f;   // Bit probe chosen by multiplier operand.
    localparam logic [7:0]  OP_DD_SRC      = 8'ha8;   // Data copy, source immediate.
    localparam logic [7:0]  OP_DD_DST      = 8'ha9;   // Data copy, destination immediate.
    localparam logic [7:0]  OP_PD_COPY     = 8'ha5;   // Program to data copy.
    localparam logic [11:0] OP_STATUS_HI   = 12'hbe4; // Status operations, low nibble selects.
    localparam logic [3:0]  ST_CFG_DATA    = 4'h4;
    localparam logic [3:0]  ST_INT_EN      = 4'h0;
    localparam logic [3:0]  ST_CLR_CARRY   = 4'he;
    localparam logic [3:0]  ST_CLR_OVM     = 4'h2;
    localparam logic [3:0]  ST_CLR_SXM     = 4'h6;
    localparam logic [3:0]  ST_CLR_TC      = 4'ha;
    localparam logic [3:0]  ST_CLR_XF      = 4'hc;
    localparam logic [13:0] OP_AUX_CMP     = 14'h2fd1; // 1011 1111 0100 01, then two-bit condition.
    localparam logic [7:0]  OP_MEM_SHIFT   = 8'h77;
    localparam logic [7:0]  OP_PORT_IN     = 8'haf;
    localparam logic [3:0]  OP_ACC_SHIFT   = 4'h1;
    localparam logic [11:0] OP_ACC_LONG    = 12'hbf8;
    localparam logic [7:0]  OP_ACC_HIGH    = 8'h6a;

    // ************************************************************
    // Cycle counts
    // ************************************************************
    localparam logic [2:0] CYC_ONE         = 3'h1;
    localparam logic [2:0] CYC_TWO         = 3'h2;
    localparam logic [2:0] CYC_THREE       = 3'h3;
    localparam logic [2:0] CYC_BR_TAKEN    = 3'h4;
    localparam logic [2:0] CYC_BR_NOT      = 3'h2;

    // ************************************************************
    // Operation codes and decode result
    // ************************************************************
    typedef enum logic [4:0] {
        OPK_NONE, OPK_BRANCH, OPK_PROBE, OPK_PROBE_MULTIPLIER_OPERAND_REG, OPK_DD_SRC, OPK_DD_DST, OPK_PD_COPY,
        OPK_CFG_DATA, OPK_INT_EN, OPK_CLR_CARRY, OPK_CLR_OVM, OPK_CLR_SXM, OPK_CLR_TC,
        OPK_CLR_XF, OPK_AUX_CMP, OPK_MEM_SHIFT, OPK_PORT_IN, OPK_ACC_SHIFT, OPK_ACC_LONG,
        OPK_ACC_HIGH
    } odec_op_e;

    typedef struct packed {
        odec_op_e    op;
        logic        two_word;
        logic [7:0]  address;      // Operand address field.
        logic [3:0]  position;     // Probe position or shift count.
        logic [1:0]  compare_cond; // Compare condition field.
        logic [3:0]  cond_mask;    // Condition select mask, Z L V C.
        logic [3:0]  cond_state;
    } odec_dec_s;

endpackage

// File: hw/odec_first_word.sv
// First-word decoder for the opcode decode slice, purely combinational.
// Assumes the word is stable for the cycle in which it is presented.
`timescale 1ns/1ps
module odec_first_word (
    // Instruction word in
    input  wire logic [15:0]         word,
    // Decode result
    output odec_pkg::odec_dec_s      dec
);

    // ************************************************************
    // Pattern match
    // ************************************************************

    // Matches the word against each pattern; unknown words give no operation.
    always_comb begin
        dec              = '0;
        dec.op           = odec_pkg::OPK_NONE;
        dec.address      = word[7:0];
        dec.position     = word[11:8];
        dec.compare_cond = word[1:0];
        dec.cond_mask    = word[3:0];
        dec.cond_state   = word[7:4];
        if (word[15:8] == odec_pkg::OP_BRANCH_HI &&
            (word[7:0] == odec_pkg::OP_BR_NZ_LO || word[7:0] == odec_pkg::OP_BR_OV_LO ||
             word[7:0] == odec_pkg::OP_BR_EQ_LO)) begin
            dec.op       = odec_pkg::OPK_BRANCH;                 // see RL1 see RL2
            dec.two_word = 1'b1;
        end else if (word[15:12] == odec_pkg::OP_PROBE_NIB) begin
            dec.op = odec_pkg::OPK_PROBE;                        // see RL3
        end else if (word[15:8] == odec_pkg::OP_PROBE_MULTIPLIER_OPERAND_REG) begin
            dec.op = odec_pkg::OPK_PROBE_MULTIPLIER_OPERAND_REG;                   // see RL3
        end else if (word[15:8] == odec_pkg::OP_DD_SRC) begin
            dec.op       = odec_pkg::OPK_DD_SRC;                 // see RL4
            dec.two_word = 1'b1;
        end else if (word[15:8] == odec_pkg::OP_DD_DST) begin
            dec.op       = odec_pkg::OPK_DD_DST;                 // see RL5
            dec.two_word = 1'b1;
        end else if (word[15:8] == odec_pkg::OP_PD_COPY) begin
            dec.op       = odec_pkg::OPK_PD_COPY;                // see RL6
            dec.two_word = 1'b1;
        end else if (word[15:4] == odec_pkg::OP_STATUS_HI) begin
            unique case (word[3:0])                              // see RL8
                odec_pkg::ST_CFG_DATA:  dec.op = odec_pkg::OPK_CFG_DATA;
                odec_pkg::ST_INT_EN:    dec.op = odec_pkg::OPK_INT_EN;
                odec_pkg::ST_CLR_CARRY: dec.op = odec_pkg::OPK_CLR_CARRY;
                odec_pkg::ST_CLR_OVM:   dec.op = odec_pkg::OPK_CLR_OVM;
                odec_pkg::ST_CLR_SXM:   dec.op = odec_pkg::OPK_CLR_SXM;
                odec_pkg::ST_CLR_TC:    dec.op = odec_pkg::OPK_CLR_TC;
                odec_pkg::ST_CLR_XF:    dec.op = odec_pkg::OPK_CLR_XF;
                default:                dec.op = odec_pkg::OPK_NONE;
            endcase
        end else if (word[15:2] == odec_pkg::OP_AUX_CMP) begin
            dec.op = odec_pkg::OPK_AUX_CMP;                      // see RL9
        end else if (word[15:8] == odec_pkg::OP_MEM_SHIFT) begin
            dec.op = odec_pkg::OPK_MEM_SHIFT;                    // see RL10
        end else if (word[15:8] == odec_pkg::OP_PORT_IN) begin
            dec.op       = odec_pkg::OPK_PORT_IN;                // see RL11
            dec.two_word = 1'b1;
        end else if (word[15:12] == odec_pkg::OP_ACC_SHIFT) begin
            dec.op = odec_pkg::OPK_ACC_SHIFT;                    // see RL12
        end else if (word[15:4] == odec_pkg::OP_ACC_LONG) begin
            dec.op       = odec_pkg::OPK_ACC_LONG;               // see RL13
            dec.two_word = 1'b1;
            dec.position = word[3:0];
        end else if (word[15:8] == odec_pkg::OP_ACC_HIGH) begin
            dec.op = odec_pkg::OPK_ACC_HIGH;                     // see RL14
        end
        if (word[15:12] == odec_pkg::OP_ACC_SHIFT) begin
            dec.position = word[11:8];
        end
    end

endmodule

// File: hw/odec_decoder.sv
// Top of the opcode decode slice: word sequencing, branch condition and cycle counts.
// Assumes a fetch path with valid/ready on a 16-bit word and condition flags from the datapath.
//
// What this block does
// (RL1) Words e308 and e322 are two-word branches on accumulator nonzero and on overflow, 4 cycles taken, 2 not.
// (RL2) Word e388 is a two-word branch on accumulator zero whose second word is the target.
// (RL3) Top nibble 4 tests the bit at the position field and 6f tests the bit chosen by the multiplier operand.
// (RL4) Opcode a8 with an address byte and a source word is a two-word, three-cycle data copy.
// (RL5) Opcode a9 with an address byte and a destination word is a two-word, three-cycle data copy.
// (RL6) Opcode a5 with an address byte and a program address word copies program to data in three cycles.
// (RL7) Software keeps the data copy away from the interrupt mask, interrupt flag and global size registers.
// (RL8) Words be4x select configure-as-data, interrupt enable and the five flag clears by low nibble.
// (RL9) Word bf4 with 01 and a two-bit condition compares the current auxiliary register with the zero one.
// (RL10) Opcode 77 copies the addressed word to the next higher address in one cycle.
// (RL11) Opcode af with a port address word reads a port into data memory in two words and two cycles.
// (RL12) Top nibble 1 loads the accumulator with a shift count field in one cycle.
// (RL13) Word bf8 with a shift nibble and a constant word loads the shifted constant in two cycles.
// (RL14) Opcode 6a clears the low accumulator half and loads the high half in one cycle.
// (RL15) A branch condition holds when any masked condition bit matches the required state.
// (RL16) Every two-word opcode consumes its second word before the next instruction issues.
`timescale 1ns/1ps
module odec_decoder (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset,
    // Fetch path
    input  wire logic                fetch_valid,
    input  wire logic [15:0]         fetch_word,
    output logic                     fetch_ready,
    // Condition flags from the datapath: zero, negative, overflow, carry
    input  wire logic [3:0]          cond_flags,
    // Issued instruction
    output logic                     issue_valid,
    output odec_pkg::odec_dec_s      issue_dec,
    output logic [15:0]              issue_second,
    output logic [2:0]               issue_words,
    output logic [2:0]               issue_cycles,
    output logic                     issue_taken
);

    typedef enum logic [1:0] {
        ST_FIRST  = 2'b01,
        ST_SECOND = 2'b10
    } odec_state_e;

    odec_pkg::odec_dec_s dec_w;
    odec_state_e         state_q, state_d;
    odec_pkg::odec_dec_s held_q, held_d;
    logic                valid_q, valid_d;
    odec_pkg::odec_dec_s out_dec_q, out_dec_d;
    logic [15:0]         second_q, second_d;
    logic [2:0]          words_q, words_d;
    logic [2:0]          cycles_q, cycles_d;
    logic                taken_q, taken_d;
    logic                cond_hit;

    // ************************************************************
    // First-word decode
    // ************************************************************

    // Classifies the word on the fetch path.
    odec_first_word u_first (
        .word (fetch_word),
        .dec  (dec_w)
    );

    // Any masked condition bit that matches its required state makes the branch taken.
    assign cond_hit = |(held_q.cond_mask & ~(held_q.cond_state ^ cond_flags)); // see RL15

    // The decoder always accepts words; the second word is absorbed in its own state.
    assign fetch_ready = 1'b1;

    // ************************************************************
    // Sequencing
    // ************************************************************

    // Computes the next state and the issued instruction.
    always_comb begin
        state_d   = state_q;
        held_d    = held_q;
        valid_d   = 1'b0;
        out_dec_d = out_dec_q;
        second_d  = second_q;
        words_d   = words_q;
        cycles_d  = cycles_q;
        taken_d   = 1'b0;
        unique case (state_q)
            ST_FIRST: begin
                if (fetch_valid) begin
                    if (dec_w.two_word) begin
                        held_d  = dec_w;                 // see RL16
                        state_d = ST_SECOND;
                    end else begin
                        valid_d   = 1'b1;
                        out_dec_d = dec_w;
                        second_d  = 16'h0000;
                        words_d   = odec_pkg::CYC_ONE;
                        cycles_d  = odec_pkg::CYC_ONE;   // see RL3 see RL8 see RL9 see RL10 see RL12 see RL14
                    end
                end
            end
            ST_SECOND: begin
                if (fetch_valid) begin
                    valid_d   = 1'b1;                    // see RL16
                    out_dec_d = held_q;
                    second_d  = fetch_word;              // see RL2
                    words_d   = odec_pkg::CYC_TWO;
                    state_d   = ST_FIRST;
                    unique case (held_q.op)
                        odec_pkg::OPK_BRANCH: begin
                            taken_d  = cond_hit;         // see RL1
                            cycles_d = cond_hit ? odec_pkg::CYC_BR_TAKEN : odec_pkg::CYC_BR_NOT;
                        end
                        odec_pkg::OPK_DD_SRC, odec_pkg::OPK_DD_DST, odec_pkg::OPK_PD_COPY: begin
                            cycles_d = odec_pkg::CYC_THREE; // see RL4 see RL5 see RL6
                        end
                        default: begin
                            cycles_d = odec_pkg::CYC_TWO; // see RL11 see RL13
                        end
                    endcase
                end
            end
            default: state_d = ST_FIRST;
        endcase
    end

    // Registers the sequencing state.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q   <= ST_FIRST;
            held_q    <= '0;
            valid_q   <= 1'b0;
            out_dec_q <= '0;
            second_q  <= 16'h0000;
            words_q   <= 3'h0;
            cycles_q  <= 3'h0;
            taken_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            held_q    <= held_d;
            valid_q   <= valid_d;
            out_dec_q <= out_dec_d;
            second_q  <= second_d;
            words_q   <= words_d;
            cycles_q  <= cycles_d;
            taken_q   <= taken_d;
        end
    end

    // Drives the issued instruction from the registers.
    assign issue_valid  = valid_q;
    assign issue_dec    = out_dec_q;
    assign issue_second = second_q;
    assign issue_words  = words_q;
    assign issue_cycles = cycles_q;
    assign issue_taken  = taken_q;

endmodule

// File: tb/odec_chk.sv
// Checker for the opcode decode slice: timing and decode relations at the top ports.
// Assumes it is bound into odec_decoder and sees only that module's ports.
`timescale 1ns/1ps
module odec_chk (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                reset,
    // Fetch path and flags
    input wire logic                fetch_valid,
    input wire logic [15:0]         fetch_word,
    input wire logic                fetch_ready,
    input wire logic [3:0]          cond_flags,
    // Issued instruction
    input wire logic                issue_valid,
    input wire odec_pkg::odec_dec_s issue_dec,
    input wire logic [15:0]         issue_second,
    input wire logic [2:0]          issue_words,
    input wire logic [2:0]          issue_cycles,
    input wire logic                issue_taken
);
    logic        pend_q, pend_d, two_w, hit, first_w, second_w;
    logic [15:0] first_q, first_d;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Works out whether the next accepted word is the second word of a pair.
    always_comb begin
        two_w    = fetch_word inside {16'he308, 16'he322, 16'he388} ||
                   fetch_word[15:8] inside {8'ha8, 8'ha9, 8'ha5, 8'haf} || fetch_word[15:4] == 12'hbf8;
        first_w  = fetch_valid && !pend_q;
        second_w = fetch_valid && pend_q;
        hit      = |(first_q[3:0] & ~(first_q[7:4] ^ cond_flags));
        pend_d   = fetch_valid ? first_w && two_w : pend_q;
        first_d  = first_w ? fetch_word : first_q;
    end
    // Registers the pairing state.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pend_q  <= 1'b0;
            first_q <= 16'h0000;
        end else begin
            pend_q  <= pend_d;
            first_q <= first_d;
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    ready_always_a: assert property (fetch_ready)
        else $error("fetch path stalled");
    pair_wait_a: assert property (first_w && two_w |=> !issue_valid)
        else $error("issued before second word");
    probe_issue_a: assert property (first_w && fetch_word[15:12] == 4'h4 |=> issue_valid
        && issue_dec.op == odec_pkg::OPK_PROBE && issue_dec.position == $past(fetch_word[11:8]))
        else $error("bit probe decode wrong");
    branch_count_a: assert property (second_w && first_q[15:8] == 8'he3 |=> issue_valid
        && issue_words == 3'h2 && issue_cycles == (issue_taken ? 3'h4 : 3'h2))
        else $error("branch counts wrong");
    branch_hit_a: assert property (second_w && first_q[15:8] == 8'he3 |=> issue_taken == $past(hit))
        else $error("branch condition wrong");
    block_copy_a: assert property (second_w && first_q[15:8] inside {8'ha8, 8'ha9, 8'ha5}
        |=> issue_cycles == 3'h3 && issue_words == 3'h2 && issue_second == $past(fetch_word))
        else $error("block copy decode wrong");
    two_cycle_a: assert property (second_w && (first_q[15:8] == 8'haf || first_q[15:4] == 12'hbf8)
        |=> issue_cycles == 3'h2 && issue_words == 3'h2)
        else $error("two cycle decode wrong");
    carry_clear_a: assert property (first_w && fetch_word == 16'hbe4e |=> issue_dec.op == odec_pkg::OPK_CLR_CARRY)
        else $error("carry clear decode wrong");
    aux_compare_a: assert property (first_w && fetch_word[15:2] == odec_pkg::OP_AUX_CMP |=> issue_valid
        && issue_dec.op == odec_pkg::OPK_AUX_CMP && issue_dec.compare_cond == $past(fetch_word[1:0]))
        else $error("aux compare decode wrong");
    one_cycle_a: assert property (first_w && (fetch_word[15:8] inside {8'h77, 8'h6a} || fetch_word[15:12] == 4'h1)
        |=> issue_valid && issue_cycles == 3'h1 && issue_words == 3'h1)
        else $error("one cycle decode wrong");
    // Main scenarios reached.
    cov_taken: cover property (issue_valid && issue_taken);
    cov_not_taken: cover property (issue_valid && issue_cycles == 3'h2 && issue_dec.op == odec_pkg::OPK_BRANCH);
    cov_copy: cover property (issue_valid && issue_cycles == 3'h3);
endmodule

// File: tb/odec_fetch_model.sv
// Model of the program fetch path that feeds the decoder, one word at a time.
// Assumes the bench queues words through the send task; slow adds random gaps.
`timescale 1ns/1ps
module odec_fetch_model (
    // Clock, reset and pacing
    input wire logic    sys_clk,
    input wire logic    reset,
    input wire logic    slow,
    // Fetch path
    output logic        fetch_valid,
    output logic [15:0] fetch_word
);
    logic [15:0] words_q[$];
    // Queues one word for fetch.
    task automatic send(input logic [15:0] w);
        words_q.push_back(w);
    endtask
    // Words leave in order, so a second word always follows its first; idle words are inverted.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fetch_valid <= 1'b0;
            fetch_word  <= 16'h0000;
        end else if (words_q.size() != 0 && !(slow && $urandom_range(1, 0) == 0)) begin
            fetch_valid <= 1'b1;
            fetch_word  <= words_q.pop_front();
        end else begin
            fetch_valid <= 1'b0;
            fetch_word  <= ~fetch_word;
        end
    end
endmodule

// File: tb/tb.sv
// Testbench for the opcode decode slice, compared with a queue-based model.
// Assumes odec_pkg, odec_decoder and the fetch model are compiled first.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        odec_pkg::odec_dec_s dec;
        logic [15:0]         second;
        logic [2:0]          words;
        logic [2:0]          cycles;
        logic                taken;
    } odec_exp_s;
    logic                sys_clk, reset, slow, fetch_valid, fetch_ready, issue_valid, issue_taken, pend;
    logic [15:0]         fetch_word, issue_second, first;
    logic [3:0]          cond_flags;
    logic [2:0]          issue_words, issue_cycles;
    odec_pkg::odec_dec_s issue_dec;
    odec_exp_s           exp_q[$];
    int                  n_errors, num_checks;
    logic [15:0]         kinds[21] = '{16'he308, 16'he322, 16'he388, 16'h4000, 16'h6f00, 16'ha800, 16'ha900,
        16'ha500, 16'hbe44, 16'hbe40, 16'hbe4e, 16'hbe42, 16'hbe46, 16'hbe4a, 16'hbe4c, 16'hbf44, 16'h7700,
        16'haf00, 16'h1000, 16'hbf80, 16'h6a00};
    odec_fetch_model u_odec_fetch_model (.sys_clk, .reset, .slow, .fetch_valid, .fetch_word);
    odec_decoder u_odec_decoder (.sys_clk, .reset, .fetch_valid, .fetch_word, .fetch_ready, .cond_flags,
        .issue_valid, .issue_dec, .issue_second, .issue_words, .issue_cycles, .issue_taken);
    // Reference decode of a first word, its second word and the flags.
    function automatic odec_exp_s model(input logic [15:0] w, input logic [15:0] s, input logic [3:0] f);
        odec_exp_s e;
        e = '0;
        e.words = 3'h1;
        e.cycles = 3'h1;
        e.dec = '{op: odec_pkg::OPK_NONE, two_word: 1'b0, address: w[7:0], position: 4'h0,
            compare_cond: w[1:0], cond_mask: w[3:0], cond_state: w[7:4]};
        case (w[15:8])
            8'he3: if (w[7:0] inside {8'h08, 8'h22, 8'h88}) e.dec.op = odec_pkg::OPK_BRANCH;
            8'h6f: e.dec.op = odec_pkg::OPK_PROBE_MULTIPLIER_OPERAND_REG;
            8'ha8: e.dec.op = odec_pkg::OPK_DD_SRC;
            8'ha9: e.dec.op = odec_pkg::OPK_DD_DST;
            8'ha5: e.dec.op = odec_pkg::OPK_PD_COPY;
            8'haf: e.dec.op = odec_pkg::OPK_PORT_IN;
            8'h77: e.dec.op = odec_pkg::OPK_MEM_SHIFT;
            8'h6a: e.dec.op = odec_pkg::OPK_ACC_HIGH;
            8'hbe: if (w[7:4] == 4'h4) begin
                case (w[3:0])
                    4'h4: e.dec.op = odec_pkg::OPK_CFG_DATA;
                    4'h0: e.dec.op = odec_pkg::OPK_INT_EN;
                    4'he: e.dec.op = odec_pkg::OPK_CLR_CARRY;
                    4'h2: e.dec.op = odec_pkg::OPK_CLR_OVM;
                    4'h6: e.dec.op = odec_pkg::OPK_CLR_SXM;
                    4'ha: e.dec.op = odec_pkg::OPK_CLR_TC;
                    4'hc: e.dec.op = odec_pkg::OPK_CLR_XF;
                    default: e.dec.op = odec_pkg::OPK_NONE;
                endcase
            end
            8'hbf: if (w[7:2] == 6'h11) e.dec.op = odec_pkg::OPK_AUX_CMP;
                else if (w[7:4] == 4'h8) e.dec.op = odec_pkg::OPK_ACC_LONG;
            default: if (w[15:12] == 4'h4) e.dec.op = odec_pkg::OPK_PROBE;
                else if (w[15:12] == 4'h1) e.dec.op = odec_pkg::OPK_ACC_SHIFT;
        endcase
        if (e.dec.op inside {odec_pkg::OPK_PROBE, odec_pkg::OPK_ACC_SHIFT}) e.dec.position = w[11:8];
        if (e.dec.op == odec_pkg::OPK_ACC_LONG) e.dec.position = w[3:0];
        if (w[15:8] inside {8'ha8, 8'ha9, 8'ha5, 8'haf} || w[15:4] == 12'hbf8 || e.dec.op == odec_pkg::OPK_BRANCH) begin
            e.dec.two_word = 1'b1;
            e.second = s;
            e.words = 3'h2;
            e.taken = w[15:8] == 8'he3 && |(w[3:0] & ~(w[7:4] ^ f));
            e.cycles = w[15:8] == 8'he3 ? (e.taken ? 3'h4 : 3'h2) : (w[15:12] == 4'ha && w[11:8] != 4'hf ? 3'h3 : 3'h2);
        end
        return e;
    endfunction
    // Compares one value and counts it.
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Sends every kind several times with random fields, then random words.
    task automatic run_test(input int t);
        logic [15:0] w, s;
        for (int i = 0; i < 200; i++) begin
            w = i < 168 ? kinds[i % 21] : 16'($urandom);
            if (w[15:8] == 8'he3 && i >= 168) w[15:8] = 8'h00;
            if (i < 168 && w[7:0] == 8'h00) w[7:0] = 8'($urandom) | 8'h80;
            if (w[15:12] inside {4'h4, 4'h1}) w[11:8] = 4'($urandom);
            if (w[15:4] == 12'hbf8) w[3:0] = 4'($urandom);
            if (w[15:2] == 14'h2fd1) w[1:0] = 2'($urandom);
            s = 16'($urandom) | 16'h0300;
            u_odec_fetch_model.send(w);
            if (model(w, s, 4'h0).words == 3'h2) u_odec_fetch_model.send(s);
        end
        for (int i = 0; i < 3000 && (u_odec_fetch_model.words_q.size() != 0 || exp_q.size() != 0); i++) @(posedge sys_clk);
        // Lets the last word be taken, expected and compared before the queues are judged.
        repeat (3) @(posedge sys_clk);
        check(64'(exp_q.size() + u_odec_fetch_model.words_q.size()), 64'h0);
        $display("test %0d done, checks %0d", t, num_checks);
    endtask
    // Clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Random condition flags every cycle.
    always @(posedge sys_clk) cond_flags <= 4'($urandom);
    // Builds expectations from the accepted words.
    always @(posedge sys_clk) if (!reset && fetch_valid && fetch_ready) begin
        if (pend) exp_q.push_back(model(first, fetch_word, cond_flags));
        else if (model(fetch_word, 16'h0, 4'h0).words == 3'h1) exp_q.push_back(model(fetch_word, 16'h0, 4'h0));
        first = pend ? first : fetch_word;
        pend = !pend && model(fetch_word, 16'h0, 4'h0).words == 3'h2;
    end
    // Compares each issue with the oldest expectation.
    always @(negedge sys_clk) if (!reset && issue_valid) begin
        odec_exp_s e, s;
        e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
        s = '{dec: issue_dec, second: issue_second, words: issue_words, cycles: issue_cycles, taken: issue_taken};
        if (!(e.dec.op inside {odec_pkg::OPK_PROBE, odec_pkg::OPK_ACC_SHIFT, odec_pkg::OPK_ACC_LONG})) s.dec.position = 4'h0;
        check(64'(s.dec), 64'(e.dec));
        check(64'({s.second, s.words, s.cycles, s.taken}), 64'({e.second, e.words, e.cycles, e.taken}));
    end
    // Main sequence: reset, prompt fetch, then slow fetch.
    initial begin
        reset = 1'b1;
        slow = 1'b0;
        cond_flags = 4'h0;
        pend = 1'b0;
        first = 16'h0000;
        n_errors = 0;
        num_checks = 0;
        void'($urandom(24));
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        run_test(0);
        slow <= 1'b1;
        run_test(1);
        test_done();
    end
    // Watchdog against a hang.
    initial begin
        #200us;
        n_errors++;
        test_done();
    end
endmodule
bind odec_decoder odec_chk u_chk (.sys_clk, .reset, .fetch_valid, .fetch_word, .fetch_ready, .cond_flags,
    .issue_valid, .issue_dec, .issue_second, .issue_words, .issue_cycles, .issue_taken);
